// File: pkg/charge_adc_cfg_pkg.sv
// Shared constants of the charge and ADC configuration register bank.
package charge_adc_cfg_pkg;
   // Register offsets.
   localparam logic [7:0] CHARGE_PROTOCOL_CONTROL_1_ADDR   = 8'h9D;
   localparam logic [7:0] LOW_SUPPLY_THRESHOLD_SELECT_ADDR = 8'hAC;
   localparam logic [7:0] ADC_CONTROL_ADDR                 = 8'hC0;
   // Reset values.
   localparam logic [7:0] CHARGE_PROTOCOL_CONTROL_1_RST    = 8'h00;
   localparam logic [7:0] LOW_SUPPLY_THRESHOLD_SELECT_RST  = 8'h00;
   localparam logic [7:0] ADC_CONTROL_RST                  = 8'h81;
   // Field positions in charge_protocol_control_1.
   localparam int FB_SCALE_BIT      = 7;
   localparam int FB_ENABLE_BIT     = 4;
   localparam int CLASS_A_BIT       = 3;
   localparam int HIGH_STEP_DIS_BIT = 0;
   // Field positions in low_supply_threshold_select and adc_control.
   localparam int LS_SEL_LSB        = 0;
   localparam int LS_SEL_W          = 3;
   localparam int LS_WRITABLE_MASK  = 8'h07;
   localparam int TM_SEL_LSB        = 5;
   localparam int DEB_LSB           = 3;
   localparam int SCAN_LSB          = 0;
   localparam logic [2:0] SCAN_CODE_MAX = 3'h5;
   // Voltage level codes of the charging protocol.
   localparam logic [1:0] LEVEL_5V  = 2'h0;
   localparam logic [1:0] LEVEL_9V  = 2'h1;
   localparam logic [1:0] LEVEL_12V = 2'h2;
   localparam logic [1:0] LEVEL_20V = 2'h3;
   // Comparator flag indices: VDD above 2.6 V, 2.8 V and 3.0 V.
   localparam logic [1:0] CMP_2P6 = 2'h0;
   localparam logic [1:0] CMP_2P8 = 2'h1;
   localparam logic [1:0] CMP_3P0 = 2'h2;
   // Timing: shortest scan interval and the clock rate.
   localparam int CLK_HZ           = 100_000_000;
   localparam int SCAN_BASE_MS     = 4;
   localparam int SCAN_BASE_CYCLES = SCAN_BASE_MS * (CLK_HZ / 1000);
   // Conversion sequencer states, Gray coded.
   typedef enum logic [1:0] {
      SCAN_WAIT  = 2'b00,
      SCAN_START = 2'b01,
      SCAN_BUSY  = 2'b11
   } scan_state_t;
endpackage : charge_adc_cfg_pkg

// File: verilog/charge_adc_config_regs.sv
// Charge protocol, low-supply and housekeeping ADC configuration register bank.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - The feedback current scale select chooses 50k (0) or 100k (1) upper resistor scaling.
// R2 - The feedback output steers the power stage only while its enable bit is one.
// R3 - Class B (select 0) offers 5, 9, 12 and 20 V; class A (select 1) offers 5, 9 and 12 V.
// R4 - The high-step disable bit removes 12 V, leaving only 5 and 9 V.
// R5 - Threshold code 000 turns the sink switch off above 2.8 V and on below 2.6 V.
// R6 - Code 001 uses 3.0/3.0 V, codes 010 and 011 use 2.6/3.0 V, code 100 uses 2.8/3.0 V.
// R7 - A 2-bit field selects the thermistor drive current of 1.25, 5, 20 or 100 uA.
// R8 - Conversions start every 4 ms to 128 ms and repeat for a debounce count of zero to three.
// R9 - Reset loads every field's default and reserved read-write bits hold what was written.
module charge_adc_config_regs #(
   parameter int SCAN_BASE_CYCLES = charge_adc_cfg_pkg::SCAN_BASE_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic [2:0] vdd_above_i,
   input  wire logic [1:0] charge_level_req_i,
   input  wire logic       adc_done_i,
   output logic            feedback_current_scale_sel_o,
   output logic            feedback_output_enable_o,
   output logic      [3:0] charge_levels_allowed_o,
   output logic      [1:0] charge_level_grant_o,
   output logic            sink_switch_on_o,
   output logic      [1:0] thermistor_current_sel_o,
   output logic            adc_start_o
);

   // Allowed level mask, one bit per level code.
   function automatic logic [3:0] allowed_levels(input logic class_a, input logic high_dis);
      logic [3:0] m;
      m = 4'hF;
      if (class_a)
      begin
         m[charge_adc_cfg_pkg::LEVEL_20V] = 1'b0; // R3
      end
      if (high_dis)
      begin
         m[charge_adc_cfg_pkg::LEVEL_12V] = 1'b0; // R4
         m[charge_adc_cfg_pkg::LEVEL_20V] = 1'b0; // R4
      end
      return m;
   endfunction : allowed_levels

   // Highest allowed level not above the request; 5 V is always allowed.
   function automatic logic [1:0] grant_level(input logic [1:0] req, input logic [3:0] m);
      logic [1:0] g;
      g = charge_adc_cfg_pkg::LEVEL_5V;
      for (int i = 0; i < 4; i++)
      begin
         if (m[i] && (2'(i) <= req))
         begin
            g = 2'(i);
         end
      end
      return g;
   endfunction : grant_level

   // Register storage and outputs.
   logic [7:0]  ctrl1_reg, ctrl1_next;
   logic [7:0]  lsel_reg, lsel_next;
   logic [7:0]  adcc_reg, adcc_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic [3:0]  allow_reg, allow_next;
   logic [1:0]  grant_reg, grant_next;
   logic        fb_en_reg, fb_en_next;
   logic        fb_sc_reg, fb_sc_next;
   logic [1:0]  tm_reg, tm_next;
   // Supply comparator synchroniser and switch state.
   logic [2:0]  cmp_meta_reg, cmp_sync_reg;
   logic        sink_reg, sink_next;
   // Conversion sequencer.
   charge_adc_cfg_pkg::scan_state_t state_reg, state_next;
   logic [31:0] timer_reg, timer_next;
   logic [1:0]  repeat_reg, repeat_next;
   logic        start_reg, start_next;
   logic [2:0]  scan_code;
   logic [31:0] interval;
   logic [1:0]  fall_idx, rise_idx;

   // Register writes and reads; unmapped reads return zero, reserved bits of 0x9D and 0xC0 keep their data, those of 0xAC read zero.
   always_comb
   begin
      ctrl1_next = ctrl1_reg;
      lsel_next  = lsel_reg;
      adcc_next  = adcc_reg;
      rdata_next = rdata_reg;
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            charge_adc_cfg_pkg::CHARGE_PROTOCOL_CONTROL_1_ADDR: ctrl1_next = reg_wdata_i; // R9
            charge_adc_cfg_pkg::LOW_SUPPLY_THRESHOLD_SELECT_ADDR:
               lsel_next = reg_wdata_i & 8'(charge_adc_cfg_pkg::LS_WRITABLE_MASK);
            charge_adc_cfg_pkg::ADC_CONTROL_ADDR: adcc_next = reg_wdata_i; // R9
            default: ;
         endcase
      end
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            charge_adc_cfg_pkg::CHARGE_PROTOCOL_CONTROL_1_ADDR:   rdata_next = ctrl1_reg;
            charge_adc_cfg_pkg::LOW_SUPPLY_THRESHOLD_SELECT_ADDR: rdata_next = lsel_reg;
            charge_adc_cfg_pkg::ADC_CONTROL_ADDR:                 rdata_next = adcc_reg;
            default:                                              rdata_next = 8'h00;
         endcase
      end
   end

   // Decoded controls, registered so every output comes from a flip-flop.
   always_comb
   begin
      fb_sc_next = ctrl1_reg[charge_adc_cfg_pkg::FB_SCALE_BIT];  // R1
      fb_en_next = ctrl1_reg[charge_adc_cfg_pkg::FB_ENABLE_BIT]; // R2
      allow_next = allowed_levels(ctrl1_reg[charge_adc_cfg_pkg::CLASS_A_BIT],
                                  ctrl1_reg[charge_adc_cfg_pkg::HIGH_STEP_DIS_BIT]); // R3 R4
      grant_next = grant_level(charge_level_req_i, allow_next); // R3 R4
      tm_next    = adcc_reg[charge_adc_cfg_pkg::TM_SEL_LSB +: 2]; // R7
   end

   // Threshold pair per code; undefined codes fall back to the 000 pair.
   always_comb
   begin
      unique case (lsel_reg[charge_adc_cfg_pkg::LS_SEL_LSB +: charge_adc_cfg_pkg::LS_SEL_W])
         3'h1:
         begin
            fall_idx = charge_adc_cfg_pkg::CMP_3P0; // R6
            rise_idx = charge_adc_cfg_pkg::CMP_3P0; // R6
         end
         3'h2,
         3'h3:
         begin
            fall_idx = charge_adc_cfg_pkg::CMP_2P6; // R6
            rise_idx = charge_adc_cfg_pkg::CMP_3P0; // R6
         end
         3'h4:
         begin
            fall_idx = charge_adc_cfg_pkg::CMP_2P8; // R6
            rise_idx = charge_adc_cfg_pkg::CMP_3P0; // R6
         end
         default:
         begin
            fall_idx = charge_adc_cfg_pkg::CMP_2P6; // R5
            rise_idx = charge_adc_cfg_pkg::CMP_2P8; // R5
         end
      endcase
      // Between the thresholds the switch holds, which gives the hysteresis.
      sink_next = sink_reg;
      if (!cmp_sync_reg[fall_idx])
      begin
         sink_next = 1'b1; // R5
      end
      else if (cmp_sync_reg[rise_idx])
      begin
         sink_next = 1'b0; // R5
      end
   end

   // Scan interval doubles per code; codes above 101 are clamped to the longest interval.
   always_comb
   begin
      scan_code = adcc_reg[charge_adc_cfg_pkg::SCAN_LSB +: 3];
      if (scan_code > charge_adc_cfg_pkg::SCAN_CODE_MAX)
      begin
         scan_code = charge_adc_cfg_pkg::SCAN_CODE_MAX;
      end
      interval    = 32'(SCAN_BASE_CYCLES) << scan_code; // R8
      state_next  = state_reg;
      timer_next  = timer_reg;
      repeat_next = repeat_reg;
      start_next  = 1'b0;
      unique case (state_reg)
         charge_adc_cfg_pkg::SCAN_WAIT:
         begin
            timer_next = timer_reg + 32'h1;
            if (timer_reg + 32'h1 >= interval)
            begin
               timer_next  = 32'h0;
               repeat_next = adcc_reg[charge_adc_cfg_pkg::DEB_LSB +: 2]; // R8
               state_next  = charge_adc_cfg_pkg::SCAN_START;
            end
         end
         charge_adc_cfg_pkg::SCAN_START:
         begin
            // Counting here too keeps the scan period equal to the interval.
            timer_next = timer_reg + 32'h1; // R8
            start_next = 1'b1; // R8
            state_next = charge_adc_cfg_pkg::SCAN_BUSY;
         end
         charge_adc_cfg_pkg::SCAN_BUSY:
         begin
            // The interval keeps counting during conversion so the period stays steady.
            timer_next = timer_reg + 32'h1;
            if (adc_done_i)
            begin
               if (repeat_reg != 2'h0)
               begin
                  repeat_next = repeat_reg - 2'h1; // R8
                  state_next  = charge_adc_cfg_pkg::SCAN_START;
               end
               else
               begin
                  state_next = charge_adc_cfg_pkg::SCAN_WAIT;
               end
            end
         end
         default: state_next = charge_adc_cfg_pkg::SCAN_WAIT;
      endcase
   end

   // All state; the clock enable freezes everything, the comparators pass two flops first.
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl1_reg    <= charge_adc_cfg_pkg::CHARGE_PROTOCOL_CONTROL_1_RST;   // R9
         lsel_reg     <= charge_adc_cfg_pkg::LOW_SUPPLY_THRESHOLD_SELECT_RST; // R9
         adcc_reg     <= charge_adc_cfg_pkg::ADC_CONTROL_RST;                 // R9
         rdata_reg    <= 8'h00;
         allow_reg    <= 4'hF;
         grant_reg    <= 2'h0;
         fb_en_reg    <= 1'b0;
         fb_sc_reg    <= 1'b0;
         tm_reg       <= 2'h0;
         cmp_meta_reg <= 3'h0;
         cmp_sync_reg <= 3'h0;
         sink_reg     <= 1'b1; // Assume a dead supply until the comparators say otherwise.
         state_reg    <= charge_adc_cfg_pkg::SCAN_WAIT;
         timer_reg    <= 32'h0;
         repeat_reg   <= 2'h0;
         start_reg    <= 1'b0;
      end
      else if (ce_i)
      begin
         ctrl1_reg    <= ctrl1_next;
         lsel_reg     <= lsel_next;
         adcc_reg     <= adcc_next;
         rdata_reg    <= rdata_next;
         allow_reg    <= allow_next;
         grant_reg    <= grant_next;
         fb_en_reg    <= fb_en_next;
         fb_sc_reg    <= fb_sc_next;
         tm_reg       <= tm_next;
         cmp_meta_reg <= vdd_above_i;
         cmp_sync_reg <= cmp_meta_reg;
         sink_reg     <= sink_next;
         state_reg    <= state_next;
         timer_reg    <= timer_next;
         repeat_reg   <= repeat_next;
         start_reg    <= start_next;
      end
   end

   // Output drive.
   assign reg_rdata_o                  = rdata_reg;
   assign feedback_current_scale_sel_o = fb_sc_reg;
   assign feedback_output_enable_o     = fb_en_reg;
   assign charge_levels_allowed_o      = allow_reg;
   assign charge_level_grant_o         = grant_reg;
   assign sink_switch_on_o             = sink_reg;
   assign thermistor_current_sel_o     = tm_reg;
   assign adc_start_o                  = start_reg;

endmodule : charge_adc_config_regs

// File: verif/adc_model.sv
// Behavioural housekeeping ADC that answers a start pulse with a done pulse; a start while one is pending restarts the wait.
`timescale 1ns/1ps
module adc_model #(
   parameter int DONE_DELAY = 2
) (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   output logic            done_o,
   output logic      [7:0] count_o
);
   logic [3:0] wait_reg  = 4'h0;
   logic       done_reg  = 1'b0;
   logic [7:0] count_reg = 8'h00;
   // Outputs come from one process each, so every signal has a single driver.
   assign done_o  = done_reg;
   assign count_o = count_reg;
   // Starts are counted; done comes DONE_DELAY cycles later and lasts one cycle.
   always @(posedge clk_i)
   begin
      done_reg <= (wait_reg == 4'h1);
      wait_reg <= start_i ? 4'(DONE_DELAY) : wait_reg - 4'(wait_reg != 4'h0);
      count_reg <= count_reg + 8'(start_i);
   end
endmodule : adc_model

// File: verif/charge_adc_config_regs_sva.sv
// Port assertions for the charge and ADC configuration register bank.
`timescale 1ns/1ps
module charge_adc_config_regs_sva #(
   parameter int SCAN_BASE_CYCLES = 16
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic [2:0] vdd_above_i,
   input wire logic       feedback_current_scale_sel_o,
   input wire logic       feedback_output_enable_o,
   input wire logic [3:0] charge_levels_allowed_o,
   input wire logic       sink_switch_on_o,
   input wire logic [1:0] thermistor_current_sel_o,
   input wire logic       adc_start_o
);
   logic [2:0]  ls_reg, ls_next;
   logic [4:0]  scan_reg, scan_next;
   logic [15:0] gap_reg, gap_next;
   wire         wr_ok = ce_i && reg_wr_i;
   wire  [2:0]  code = (scan_reg[2:0] > 3'h5) ? 3'h5 : scan_reg[2:0];
   wire  [15:0] span = 16'(SCAN_BASE_CYCLES) << code;
   // Gap counts cycles since the last start; 0 means unknown after a change, a freeze or with a non-zero debounce count.
   always_comb
   begin
      ls_next = (wr_ok && reg_addr_i == 8'hAC) ? reg_wdata_i[2:0] : ls_reg;
      scan_next = (wr_ok && reg_addr_i == 8'hC0) ? reg_wdata_i[4:0] : scan_reg;
      gap_next = adc_start_o ? 16'h0001 : gap_reg + 16'(gap_reg != 16'h0000);
      if (!ce_i || scan_next != scan_reg || scan_reg[4:3] != 2'h0)
         gap_next = 16'h0000;
   end
   // Helper state mirrors what was written and counts cycles since the last start.
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i)
         {ls_reg, scan_reg, gap_reg} <= {3'h0, 5'h01, 16'h0000};
      else
         {ls_reg, scan_reg, gap_reg} <= {ls_next, scan_next, gap_next};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   scale_follow_a: assert property ((wr_ok && reg_addr_i == 8'h9D) ##1 ce_i |=>
      feedback_current_scale_sel_o == $past(reg_wdata_i[7], 2)) else $error("scale select wrong");
   enable_follow_a: assert property ((wr_ok && reg_addr_i == 8'h9D) ##1 ce_i |=>
      feedback_output_enable_o == $past(reg_wdata_i[4], 2)) else $error("feedback enable wrong");
   levels_follow_a: assert property ((wr_ok && reg_addr_i == 8'h9D) ##1 ce_i |=>
      charge_levels_allowed_o == {~$past(reg_wdata_i[3], 2) & ~$past(reg_wdata_i[0], 2),
      ~$past(reg_wdata_i[0], 2), 2'b11}) else $error("allowed levels wrong");
   drive_follow_a: assert property ((wr_ok && reg_addr_i == 8'hC0) ##1 ce_i |=>
      thermistor_current_sel_o == $past(reg_wdata_i[6:5], 2)) else $error("drive select wrong");
   sink_dead_a: assert property ((ce_i && vdd_above_i == 3'h0)[*4] |=>
      sink_switch_on_o) else $error("sink switch not on below all thresholds");
   sink_code0_a: assert property ((ce_i && (ls_reg == 3'h0 || ls_reg > 3'h4)
      && vdd_above_i == 3'h3)[*4] |=> !sink_switch_on_o) else $error("sink switch not off");
   sink_code1_a: assert property ((ce_i && ls_reg == 3'h1 && vdd_above_i == 3'h3)[*4]
      |=> sink_switch_on_o) else $error("sink switch not on for code 1");
   sink_code4_a: assert property ((ce_i && ls_reg == 3'h4 && vdd_above_i == 3'h1)[*4]
      |=> sink_switch_on_o) else $error("sink switch not on for code 4");
   scan_interval_a: assert property (adc_start_o && gap_reg != 16'h0000 |->
      gap_reg == span) else $error("scan interval wrong");
endmodule : charge_adc_config_regs_sva
bind charge_adc_config_regs charge_adc_config_regs_sva #(.SCAN_BASE_CYCLES(SCAN_BASE_CYCLES))
   charge_adc_config_regs_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .vdd_above_i(vdd_above_i), .feedback_current_scale_sel_o(feedback_current_scale_sel_o),
   .feedback_output_enable_o(feedback_output_enable_o), .adc_start_o(adc_start_o),
   .charge_levels_allowed_o(charge_levels_allowed_o), .sink_switch_on_o(sink_switch_on_o),
   .thermistor_current_sel_o(thermistor_current_sel_o));

// File: verif/charge_adc_config_regs_test.sv
// Self-checking bench for the charge and ADC configuration register bank.
`timescale 1ns/1ps
module charge_adc_config_regs_test;
   localparam int BASE = 16;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       ce_i = 1'b1;
   logic       reg_wr_i = 1'b0;
   logic       reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [2:0] vdd_above_i = 3'h0;
   logic [1:0] req = 2'h0;
   logic       done, scale, enable, sink, start;
   logic [7:0] rdata, starts, seen;
   logic [3:0] allowed;
   logic [1:0] grant, drive, top;
   // Threshold table: code in [6:4], comparator flags in [3:1], expected switch in [0].
   logic [6:0] tbl [16] = '{7'h06, 7'h02, 7'h01, 7'h03, 7'h17, 7'h1E, 7'h26, 7'h21,
                            7'h27, 7'h4E, 7'h46, 7'h43, 7'h56, 7'h31, 7'h37, 7'h76};
   int         bad_count = 0;
   int         total_checks = 0;
   always #5 clk_i = ~clk_i;
   charge_adc_config_regs #(.SCAN_BASE_CYCLES(BASE)) charge_adc_config_regs_inst (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(rdata), .vdd_above_i(vdd_above_i), .charge_level_req_i(req),
      .adc_done_i(done), .feedback_current_scale_sel_o(scale), .feedback_output_enable_o(enable),
      .charge_levels_allowed_o(allowed), .charge_level_grant_o(grant),
      .sink_switch_on_o(sink), .thermistor_current_sel_o(drive), .adc_start_o(start));
   adc_model #(.DONE_DELAY(2)) adc_model_inst (.clk_i(clk_i), .start_i(start),
      .done_o(done), .count_o(starts));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   // Each access leaves one quiet edge so a strobe is never set twice in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(posedge clk_i);
      chk("read data", e, rdata);
   endtask : rd
   task automatic give_verdict;
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // Waits until no start has come for 20 cycles, so the next start opens a scan.
   task automatic wait_quiet;
      int idle;
      idle = 0;
      for (int n = 0; n < 3000 && idle < 20; n++)
      begin
         seen = starts;
         @(posedge clk_i);
         idle = (starts == seen) ? idle + 1 : 0;
      end
      if (idle < 20)
      begin
         bad_count++;
         give_verdict();
      end
   endtask : wait_quiet
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("sink switch", 8'h01, 8'(sink));
      rd(8'h9D, 8'h00);
      rd(8'hAC, 8'h00);
      rd(8'hC0, 8'h81);
      rd(8'h55, 8'h00);
      for (int k = 0; k < 16; k++)
      begin
         wr(8'h9D, {k[3], 2'b10, k[2], k[1], 2'b01, k[0]});
         rd(8'h9D, {k[3], 2'b10, k[2], k[1], 2'b01, k[0]});
         chk("scale select", 8'(k[3]), 8'(scale));
         chk("feedback enable", 8'(k[2]), 8'(enable));
         chk("allowed", {4'h0, ~k[1] & ~k[0], ~k[0], 2'b11}, 8'(allowed));
         top = k[0] ? 2'h1 : (k[1] ? 2'h2 : 2'h3);
         for (int r = 0; r < 4; r++)
         begin
            req <= 2'(r);
            repeat (2) @(posedge clk_i);
            chk("grant", 8'((r < top) ? r : top), 8'(grant));
         end
      end
      // A write while the clock enable is low must leave the register untouched.
      ce_i <= 1'b0;
      wr(8'h9D, 8'h00);
      ce_i <= 1'b1;
      rd(8'h9D, 8'hDB);
      wr(8'hAC, 8'hFF);
      rd(8'hAC, 8'h07);
      foreach (tbl[i])
      begin
         wr(8'hAC, {5'h00, tbl[i][6:4]});
         vdd_above_i <= tbl[i][3:1];
         repeat (6) @(posedge clk_i);
         chk("sink switch", 8'(tbl[i][0]), 8'(sink));
      end
      // Scan code 2 gives 4 * BASE cycles; one scan holds debounce + 1 starts.
      for (int k = 0; k < 4; k++)
      begin
         wr(8'hC0, 8'(8'h82 + k * 8'h28));
         rd(8'hC0, 8'(8'h82 + k * 8'h28));
         chk("drive select", 8'(k), 8'(drive));
         wait_quiet();
         seen = starts;
         repeat (BASE * 4) @(posedge clk_i);
         chk("start count", 8'(k + 1), starts - seen);
      end
      // Scan code 111 must run at the longest interval, 32 * BASE cycles, so a window
      // of that length opened at least 20 cycles after a start holds exactly one start.
      wr(8'hC0, 8'h87);
      wait_quiet();
      seen = starts;
      repeat (BASE * 32) @(posedge clk_i);
      chk("start count", 8'h01, starts - seen);
      give_verdict();
   end
endmodule : charge_adc_config_regs_test
